// *** core/jtce_pkg.sv ***
// Purpose: Shared constants and types of the TAP command engine.
// Assumes: APB slave with 32-bit words, one register per word.
// Notes: TAP states, opcodes, register map and reset values live here.
// Function
// - Command write starts, clears both buffers
// - Finished command returns opcode to null
// - Setup registers frozen while command runs
// - Commands ignored in discrete pin mode
// - Move, operate for count, go end
// - State move takes direct path to end
// - State jump relabels state, TMS untouched
// - Run test idles count clocks, then ends
// - Port, IR, DR scans; four transfer kinds
// - Port scans hold TMS, keep state
// - Port scans pass raw bits only
// - IR scan stalls in Pause-IR or gates
// - DR scan stalls in Pause-DR or gates
// - Full duplex uses both buffers together
// - Input only drives serial out high
// - Output only discards incoming data
// - Recirculate echoes incoming data back out
// - Counter decrements per clock or bit
// - Counter written and read bytewise, four
// - Counter loaded flag at status bit 5
// - Any reset clears counter, marks unloaded
// - End field: RTI, Pause-DR, Pause-IR
// - Opcode decode table for all commands
// - Counter writes ignored while busy
package jtce_pkg;
	// Register byte addresses on the bus.
	localparam logic [7:0] A_SETUP1 = 8'h00;
	localparam logic [7:0] A_SETUP2 = 8'h04;
	localparam logic [7:0] A_CMD = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0c;
	localparam logic [7:0] A_CNT = 8'h10;
	localparam logic [7:0] A_TXB = 8'h14;
	localparam logic [7:0] A_RXB = 8'h18;
	// Field positions.
	localparam int B_SWRST = 7;
	localparam int B_LOADED = 5;
	localparam int B_GATED = 4;
	// Mode encodings and reset values.
	localparam logic [2:0] MODE_DISCRETE = 3'h1;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [2:0] DIV_CODE_RST = 3'h4;
	// Opcodes.
	localparam logic [3:0] OP_NULL = 4'h0;
	localparam logic [3:0] OP_RUN = 4'h2;
	localparam logic [3:0] OP_PIN = 4'h3;
	localparam logic [3:0] OP_PFD = 4'h4;
	localparam logic [3:0] OP_POUT = 4'h5;
	localparam logic [3:0] OP_MOVE = 4'h6;
	localparam logic [3:0] OP_JUMP = 4'h7;
	// End-state codes.
	localparam logic [1:0] END_PDR = 2'h2;
	localparam logic [1:0] END_PIR = 2'h3;
	// Transfer kinds.
	localparam logic [1:0] K_FULL = 2'h0;
	localparam logic [1:0] K_IN = 2'h1;
	localparam logic [1:0] K_OUT = 2'h2;
	localparam logic [1:0] K_REC = 2'h3;
	// Buffer depth in bits.
	localparam logic [5:0] BUF_BITS = 6'h20;
	localparam logic [5:0] BUF_ROOM = 6'h18;
	// Target TAP controller states.
	typedef enum logic [3:0] {TS_TLR, TS_RTI, TS_SELDR, TS_CAPDR,
		TS_SHDR, TS_EX1DR, TS_PDR, TS_EX2DR, TS_UPDR, TS_SELIR,
		TS_CAPIR, TS_SHIR, TS_EX1IR, TS_PIR, TS_EX2IR, TS_UPIR} jtce_tap_e;
	// Command phases.
	typedef enum logic [1:0] {PH_IDLE, PH_GO, PH_WORK, PH_END} jtce_ph_e;
	// Pins towards the target chain.
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdo;
	} jtce_pins_s;
	// Whole state of the engine.
	typedef struct packed {
		logic [1:0] tdi_s;
		logic [2:0] mode;
		logic [2:0] dcode;
		logic gated;
		logic [3:0] opc;
		logic [1:0] final_tap_state_field;
		jtce_ph_e ph;
		jtce_tap_e tap;
		logic [31:0] ctr;
		logic loaded;
		logic [1:0] wi;
		logic [1:0] ri;
		logic [31:0] txq;
		logic [5:0] txn;
		logic [31:0] rxq;
		logic [5:0] rxn;
		logic [6:0] dcnt;
		logic hi;
		logic act;
		logic sh;
		jtce_pins_s pins;
		logic [31:0] prd;
		logic rdy;
		logic err;
	} jtce_state_s;
endpackage : jtce_pkg

// *** core/jtce_top.sv ***
// Purpose: TAP master command engine with APB register access.
// Assumes: One 100 MHz clock; serial input arrives asynchronously.
// Notes: The test clock is made here by a divider and driven out.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module jtce_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tdi_pin,
	output jtce_pkg::jtce_pins_s tap_pins
);
	// Registered state and its next value.
	jtce_pkg::jtce_state_s st_r;
	jtce_pkg::jtce_state_s st_nxt;
	// Decoded command properties.
	logic busy;
	logic is_scan;
	logic is_port;
	logic is_dr;
	logic [1:0] kind;
	logic need_tx;
	logic need_rx;
	logic blk;
	logic will_blk;
	logic tdi_now;
	logic tick;
	logic access;
	logic in_work;
	logic [6:0] half;
	jtce_pkg::jtce_tap_e sh_goal;
	jtce_pkg::jtce_tap_e p_goal;
	jtce_pkg::jtce_tap_e w_goal;
	jtce_pkg::jtce_tap_e e_goal;

	// Next TAP state of the target for a given TMS.
	function automatic jtce_pkg::jtce_tap_e tap_next(
		input jtce_pkg::jtce_tap_e s,
		input logic t
	);
		case (s)
			jtce_pkg::TS_TLR: tap_next = t ? jtce_pkg::TS_TLR : jtce_pkg::TS_RTI;
			jtce_pkg::TS_RTI: tap_next = t ? jtce_pkg::TS_SELDR : jtce_pkg::TS_RTI;
			jtce_pkg::TS_SELDR: tap_next = t ? jtce_pkg::TS_SELIR : jtce_pkg::TS_CAPDR;
			jtce_pkg::TS_CAPDR: tap_next = t ? jtce_pkg::TS_EX1DR : jtce_pkg::TS_SHDR;
			jtce_pkg::TS_SHDR: tap_next = t ? jtce_pkg::TS_EX1DR : jtce_pkg::TS_SHDR;
			jtce_pkg::TS_EX1DR: tap_next = t ? jtce_pkg::TS_UPDR : jtce_pkg::TS_PDR;
			jtce_pkg::TS_PDR: tap_next = t ? jtce_pkg::TS_EX2DR : jtce_pkg::TS_PDR;
			jtce_pkg::TS_EX2DR: tap_next = t ? jtce_pkg::TS_UPDR : jtce_pkg::TS_SHDR;
			jtce_pkg::TS_SELIR: tap_next = t ? jtce_pkg::TS_TLR : jtce_pkg::TS_CAPIR;
			jtce_pkg::TS_CAPIR: tap_next = t ? jtce_pkg::TS_EX1IR : jtce_pkg::TS_SHIR;
			jtce_pkg::TS_SHIR: tap_next = t ? jtce_pkg::TS_EX1IR : jtce_pkg::TS_SHIR;
			jtce_pkg::TS_EX1IR: tap_next = t ? jtce_pkg::TS_UPIR : jtce_pkg::TS_PIR;
			jtce_pkg::TS_PIR: tap_next = t ? jtce_pkg::TS_EX2IR : jtce_pkg::TS_PIR;
			jtce_pkg::TS_EX2IR: tap_next = t ? jtce_pkg::TS_UPIR : jtce_pkg::TS_SHIR;
			default: tap_next = t ? jtce_pkg::TS_SELDR : jtce_pkg::TS_RTI;
		endcase
	endfunction : tap_next

	// TMS that takes the shortest step from s towards goal g.
	// Exit1 heads for Pause whenever the goal is Shift or Pause, so a resumed scan never recaptures.
	function automatic logic tms_to(
		input jtce_pkg::jtce_tap_e s,
		input jtce_pkg::jtce_tap_e g
	);
		logic gdr;
		logic gir;
		gdr = (g == jtce_pkg::TS_SHDR) || (g == jtce_pkg::TS_PDR);
		gir = (g == jtce_pkg::TS_SHIR) || (g == jtce_pkg::TS_PIR);
		case (s)
			jtce_pkg::TS_TLR: tms_to = (g == jtce_pkg::TS_TLR);
			jtce_pkg::TS_RTI: tms_to = (g != jtce_pkg::TS_RTI);
			jtce_pkg::TS_SELDR: tms_to = !gdr;
			jtce_pkg::TS_SELIR: tms_to = !gir;
			jtce_pkg::TS_CAPDR: tms_to = (g != jtce_pkg::TS_SHDR);
			jtce_pkg::TS_CAPIR: tms_to = (g != jtce_pkg::TS_SHIR);
			jtce_pkg::TS_SHDR: tms_to = (g != jtce_pkg::TS_SHDR);
			jtce_pkg::TS_SHIR: tms_to = (g != jtce_pkg::TS_SHIR);
			jtce_pkg::TS_EX1DR: tms_to = !gdr;
			jtce_pkg::TS_EX1IR: tms_to = !gir;
			jtce_pkg::TS_PDR: tms_to = (g != jtce_pkg::TS_PDR);
			jtce_pkg::TS_PIR: tms_to = (g != jtce_pkg::TS_PIR);
			jtce_pkg::TS_EX2DR: tms_to = (g != jtce_pkg::TS_SHDR);
			jtce_pkg::TS_EX2IR: tms_to = (g != jtce_pkg::TS_SHIR);
			default: tms_to = (g != jtce_pkg::TS_RTI);
		endcase
	endfunction : tms_to

	// Reset image of the whole engine.
	function automatic jtce_pkg::jtce_state_s st_reset();
		st_reset = '0;
		st_reset.mode = jtce_pkg::MODE_RST;
		st_reset.dcode = jtce_pkg::DIV_CODE_RST;
		st_reset.tap = jtce_pkg::TS_TLR;
		st_reset.pins.tms = 1'b1;
		st_reset.pins.tdo = 1'b1;
		st_reset.act = 1'b1;
	endfunction : st_reset

	// Command decode, shared by the engine and the bus logic.
	always_comb
	begin
		busy = (st_r.ph != jtce_pkg::PH_IDLE);
		is_scan = st_r.opc[3];
		is_port = (st_r.opc == jtce_pkg::OP_PIN) || (st_r.opc == jtce_pkg::OP_PFD)
			|| (st_r.opc == jtce_pkg::OP_POUT);
		is_dr = st_r.opc[0];
		// Port scans have no recirculate form; the others index by opcode.
		if (is_port)
		begin
			kind = (st_r.opc == jtce_pkg::OP_PIN) ? jtce_pkg::K_IN :
				(st_r.opc == jtce_pkg::OP_PFD) ? jtce_pkg::K_FULL : jtce_pkg::K_OUT;
		end
		else
		begin
			kind = st_r.opc[2:1];
		end
		need_tx = (kind == jtce_pkg::K_FULL) || (kind == jtce_pkg::K_OUT);
		need_rx = (kind != jtce_pkg::K_OUT);
		blk = (need_tx && (st_r.txn == 6'h00))
			|| (need_rx && (st_r.rxn == jtce_pkg::BUF_BITS));
		will_blk = (need_tx && (st_r.txn == 6'h01))
			|| (need_rx && (st_r.rxn == jtce_pkg::BUF_BITS - 6'h01));
		sh_goal = is_dr ? jtce_pkg::TS_SHDR : jtce_pkg::TS_SHIR;
		p_goal = is_dr ? jtce_pkg::TS_PDR : jtce_pkg::TS_PIR;
		// Free-running clock cannot stop, so a blocked scan parks in Pause.
		if (!is_scan)
		begin
			w_goal = jtce_pkg::TS_RTI;
		end
		else if (blk && !st_r.gated)
		begin
			w_goal = p_goal;
		end
		else
		begin
			w_goal = sh_goal;
		end
		// Code 00 also finishes in Run-Test/Idle.
		if (st_r.final_tap_state_field == jtce_pkg::END_PDR)
		begin
			e_goal = jtce_pkg::TS_PDR;
		end
		else if (st_r.final_tap_state_field == jtce_pkg::END_PIR)
		begin
			e_goal = jtce_pkg::TS_PIR;
		end
		else
		begin
			e_goal = jtce_pkg::TS_RTI;
		end
		// The fall that finds the target in its working state already works.
		// An extra idle fall here would clock one empty bit through Shift.
		in_work = (st_r.ph == jtce_pkg::PH_WORK) || (st_r.ph == jtce_pkg::PH_GO && st_r.tap == w_goal);
		tdi_now = st_r.tdi_s[1];
		half = (st_r.dcode == 3'h0) ? 7'h01 : 7'(8'h01 << (st_r.dcode - 3'h1));
		tick = (st_r.dcnt == half - 7'h01);
		access = psel && penable && st_r.rdy;
	end

	// Engine, buffers and register file as one next-state process.
	always_comb
	begin
		st_nxt = st_r;
		// Two-stage synchroniser for the serial input.
		st_nxt.tdi_s = {st_r.tdi_s[0], tdi_pin};
		// Half-period divider of the test clock.
		st_nxt.dcnt = tick ? 7'h00 : st_r.dcnt + 7'h01;
		if (tick && st_r.hi)
		begin
			// Rising edge: the target acts on the TMS set half a period ago.
			st_nxt.hi = 1'b0;
			st_nxt.pins.tck = st_r.act;
			if (st_r.act && !(busy && is_port))
			begin
				st_nxt.tap = tap_next(st_r.tap, st_r.pins.tms);
			end
			if (st_r.act && st_r.sh && need_rx)
			begin
				st_nxt.rxq = st_r.rxq | (32'(tdi_now) << st_r.rxn);
				st_nxt.rxn = st_r.rxn + 6'h01;
			end
		end
		else if (tick)
		begin
			// Falling edge: decide what the next cycle does.
			st_nxt.hi = 1'b1;
			st_nxt.pins.tck = 1'b0;
			st_nxt.act = !st_r.gated;
			st_nxt.sh = 1'b0;
			st_nxt.pins.tms = (st_r.tap == jtce_pkg::TS_TLR);
			// Arrival in the working state switches phase; the branches below then work at once.
			if (in_work)
			begin
				st_nxt.ph = jtce_pkg::PH_WORK;
			end
			if (st_r.ph == jtce_pkg::PH_GO && !in_work)
			begin
				st_nxt.act = 1'b1;
				st_nxt.pins.tms = tms_to(st_r.tap, w_goal);
			end
			else if (in_work && st_r.ctr == 32'h0)
			begin
				// Count exhausted: port scans stop, others head for the end.
				st_nxt.pins.tms = st_r.pins.tms;
				if (is_port)
				begin
					st_nxt.ph = jtce_pkg::PH_IDLE;
					st_nxt.opc = jtce_pkg::OP_NULL;
					st_nxt.act = !st_r.gated;
				end
				else
				begin
					st_nxt.ph = jtce_pkg::PH_END;
					st_nxt.act = 1'b1;
					st_nxt.pins.tms = tms_to(st_r.tap, e_goal);
				end
			end
			else if (in_work && !is_scan && !is_port)
			begin
				// Run test: hold Run-Test/Idle one clock per count.
				st_nxt.act = 1'b1;
				st_nxt.pins.tms = 1'b0;
				st_nxt.ctr = st_r.ctr - 32'h1;
			end
			else if (in_work && is_scan && st_r.tap != sh_goal)
			begin
				// Parked in Pause or on the way back to Shift.
				st_nxt.act = 1'b1;
				st_nxt.pins.tms = tms_to(st_r.tap, w_goal);
			end
			else if (in_work)
			begin
				// In Shift, or a port scan with TMS frozen.
				st_nxt.pins.tms = is_port ? st_r.pins.tms : 1'b0;
				if (blk)
				begin
					// Gated mode stops the clock until the host services a buffer.
					st_nxt.act = is_port ? 1'b0 : !st_r.gated;
					st_nxt.pins.tms = is_port ? st_r.pins.tms : 1'b1;
				end
				else
				begin
					st_nxt.act = 1'b1;
					st_nxt.sh = 1'b1;
					st_nxt.ctr = st_r.ctr - 32'h1;
					if (!is_port)
					begin
						// Leave Shift on the last bit, or early when not gated if next bit would stall.
						st_nxt.pins.tms = (st_r.ctr == 32'h1)
							|| (!st_r.gated && will_blk);
					end
					if (kind == jtce_pkg::K_IN)
					begin
						st_nxt.pins.tdo = 1'b1;
					end
					else if (kind == jtce_pkg::K_REC)
					begin
						st_nxt.pins.tdo = tdi_now;
					end
					else
					begin
						st_nxt.pins.tdo = st_r.txq[0];
						st_nxt.txq = st_r.txq >> 1;
						st_nxt.txn = st_r.txn - 6'h01;
					end
				end
			end
			else if (st_r.ph == jtce_pkg::PH_END)
			begin
				st_nxt.act = 1'b1;
				st_nxt.pins.tms = tms_to(st_r.tap, e_goal);
				if (st_r.tap == e_goal)
				begin
					st_nxt.ph = jtce_pkg::PH_IDLE;
					st_nxt.opc = jtce_pkg::OP_NULL;
					st_nxt.act = !st_r.gated;
				end
			end
		end
		// Bus read data and ready are staged in the setup cycle.
		st_nxt.prd = 32'h0;
		st_nxt.rdy = 1'b1;
		st_nxt.err = 1'b0;
		if (paddr == jtce_pkg::A_SETUP1)
		begin
			st_nxt.prd = 32'(st_r.mode);
		end
		else if (paddr == jtce_pkg::A_SETUP2)
		begin
			st_nxt.prd = 32'({st_r.dcode, st_r.gated, 4'h0});
		end
		else if (paddr == jtce_pkg::A_CMD)
		begin
			st_nxt.prd = 32'({st_r.final_tap_state_field, st_r.opc});
		end
		else if (paddr == jtce_pkg::A_STAT)
		begin
			st_nxt.prd = 32'({busy, st_r.txn == 6'h00, st_r.loaded, 1'b0, st_r.tap});
		end
		else if (paddr == jtce_pkg::A_CNT)
		begin
			st_nxt.prd = 32'(st_r.ctr[8 * st_r.ri +: 8]);
		end
		else if (paddr == jtce_pkg::A_TXB)
		begin
			// A full transmit buffer holds the write in wait states.
			st_nxt.rdy = !pwrite || (st_r.txn <= jtce_pkg::BUF_ROOM);
		end
		else if (paddr == jtce_pkg::A_RXB)
		begin
			// Wait for a whole byte; once idle a partial byte is handed out.
			st_nxt.prd = 32'(st_r.rxq[7:0]);
			st_nxt.rdy = pwrite || (st_r.rxn >= 6'h08) || !busy;
		end
		else
		begin
			st_nxt.err = 1'b1;
		end
		// Register writes take effect at the completing edge.
		if (access && pwrite)
		begin
			if (paddr == jtce_pkg::A_SETUP1 && !busy)
			begin
				st_nxt.mode = pwdata[2:0];
			end
			else if (paddr == jtce_pkg::A_SETUP2 && !busy)
			begin
				st_nxt.dcode = pwdata[7:5];
				st_nxt.gated = pwdata[jtce_pkg::B_GATED];
			end
			else if (paddr == jtce_pkg::A_CNT && !busy)
			begin
				// Least significant byte first; only the fourth write completes it.
				st_nxt.ctr[8 * st_r.wi +: 8] = pwdata[7:0];
				st_nxt.wi = st_r.wi + 2'h1;
				st_nxt.loaded = (st_r.wi == 2'h3);
			end
			else if (paddr == jtce_pkg::A_TXB)
			begin
				st_nxt.txq = st_nxt.txq | (32'(pwdata[7:0]) << st_nxt.txn);
				st_nxt.txn = st_nxt.txn + 6'h08;
			end
			else if (paddr == jtce_pkg::A_CMD && !busy
				&& st_r.mode != jtce_pkg::MODE_DISCRETE)
			begin
				// Starting a command clears both buffers and the read pointer.
				st_nxt.opc = pwdata[3:0];
				st_nxt.final_tap_state_field = pwdata[5:4];
				st_nxt.txq = 32'h0;
				st_nxt.txn = 6'h00;
				st_nxt.rxq = 32'h0;
				st_nxt.rxn = 6'h00;
				st_nxt.ri = 2'h0;
				st_nxt.wi = 2'h0;
				st_nxt.sh = 1'b0;
				if (pwdata[3:0] == jtce_pkg::OP_RUN || pwdata[3])
				begin
					st_nxt.ph = jtce_pkg::PH_GO;
				end
				else if (pwdata[3:0] == jtce_pkg::OP_PIN || pwdata[3:0] == jtce_pkg::OP_PFD
					|| pwdata[3:0] == jtce_pkg::OP_POUT)
				begin
					st_nxt.ph = jtce_pkg::PH_WORK;
				end
				else if (pwdata[3:0] == jtce_pkg::OP_MOVE)
				begin
					st_nxt.ph = jtce_pkg::PH_END;
				end
				else
				begin
					// Null, reserved and jump finish at once.
					st_nxt.opc = jtce_pkg::OP_NULL;
				end
				if (pwdata[3:0] == jtce_pkg::OP_JUMP)
				begin
					// Relabel only; TMS keeps its present value.
					if (pwdata[5:4] == jtce_pkg::END_PDR)
					begin
						st_nxt.tap = jtce_pkg::TS_PDR;
					end
					else if (pwdata[5:4] == jtce_pkg::END_PIR)
					begin
						st_nxt.tap = jtce_pkg::TS_PIR;
					end
					else
					begin
						st_nxt.tap = jtce_pkg::TS_RTI;
					end
				end
			end
		end
		// Reads with side effects.
		if (access && !pwrite)
		begin
			if (paddr == jtce_pkg::A_CNT)
			begin
				st_nxt.ri = st_r.ri + 2'h1;
			end
			else if (paddr == jtce_pkg::A_RXB)
			begin
				st_nxt.rxq = st_nxt.rxq >> 8;
				st_nxt.rxn = (st_nxt.rxn >= 6'h08) ? st_nxt.rxn - 6'h08 : 6'h00;
			end
		end
		// Software reset acts at once, whatever is running.
		if (access && pwrite && paddr == jtce_pkg::A_CMD && pwdata[jtce_pkg::B_SWRST])
		begin
			st_nxt = st_reset();
		end
	end

	// Single register stage; reset clears the counter and its flag.
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			st_r <= st_reset();
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs.
	assign prdata = st_r.prd;
	assign pready = penable && st_r.rdy;
	assign pslverr = penable && st_r.rdy && st_r.err;
	assign tap_pins = st_r.pins;
endmodule : jtce_top
`default_nettype wire

// *** tb/jtce_asserts.sv ***
// Purpose: Port checks of the TAP command engine.
// Assumes: Divider stays at its reset code, so a test clock half period is 8 clocks.
// Notes: Bound to the top module from the testbench file.
`timescale 1ns/1ns
`default_nettype none
module jtce_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tdi_pin,
	input wire jtce_pkg::jtce_pins_s tap_pins
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// Access phase, and whether it names a mapped word.
	logic acc;
	logic mapped;
	assign acc = psel && penable;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h18);
	// One high phase of the test clock; a shorter one would tear a target cycle.
	sequence s_tck_high;
		tap_pins.tck [*8] ##1 !tap_pins.tck;
	endsequence
	a_ready_in_access: assert property (pready |-> acc)
		else $error("ready outside an access phase");
	a_cmd_no_wait: assert property (acc && paddr == jtce_pkg::A_CMD |-> pready)
		else $error("command access was held");
	a_error_unmapped: assert property (acc && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	a_error_mapped: assert property (acc && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_error_data_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused read carried data");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_tms_steady_high: assert property (tap_pins.tck && $past(tap_pins.tck) |-> $stable(tap_pins.tms))
		else $error("mode select moved while test clock high");
	a_tdo_steady_high: assert property (tap_pins.tck && $past(tap_pins.tck) |-> $stable(tap_pins.tdo))
		else $error("serial out moved while test clock high");
	a_tck_half_period: assert property ($rose(tap_pins.tck) |-> s_tck_high)
		else $error("test clock high phase not 8 clocks");
endmodule : jtce_asserts
`default_nettype wire

// *** tb/jtce_target.sv ***
// Purpose: Behavioural target scan chain on the TAP pins.
// Assumes: One TAP controller; return data changes on the falling test clock.
// Notes: Outside shift states the return line toggles, so stale data never matches.
`timescale 1ns/1ns
`default_nettype none
module jtce_target (
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo,
	input wire logic clr,
	input wire logic [63:0] pat,
	output logic tdi_pin,
	output logic [3:0] st,
	output logic [63:0] rcv,
	output logic [6:0] n
);
	// Next state for mode select high and low, one nibble per state.
	localparam logic [63:0] NX1 = 64'h2fefcc0287855920;
	localparam logic [63:0] NX0 = 64'h1bddbba146644311;
	logic shift;
	assign shift = (st == 4'h4) || (st == 4'hb);
	initial st = 4'h0;
	initial tdi_pin = 1'b0;
	// Controller steps on the rising test clock.
	always @(posedge tck)
	begin
		st <= tms ? NX1[{st, 2'h0} +: 4] : NX0[{st, 2'h0} +: 4];
	end
	// Shifted bits are recorded in arrival order.
	always @(posedge tck or posedge clr)
	begin
		if (clr)
		begin
			n <= 7'h0;
			rcv <= 64'h0;
		end
		else if (shift)
		begin
			rcv[n[5:0]] <= tdo;
			n <= n + 7'h1;
		end
	end
	// Return data on the falling edge.
	always @(negedge tck)
	begin
		tdi_pin <= shift ? pat[n[5:0]] : ~tdi_pin;
	end
endmodule : jtce_target
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the TAP command engine.
// Assumes: A target chain model sits on the pins; divider left at reset code.
// Notes: Reads queue their expected word; a monitor compares at completion.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clock;
	logic rst_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic tdi_pin;
	jtce_pkg::jtce_pins_s tap_pins;
	logic clr;
	logic [63:0] pat;
	logic [3:0] st;
	logic [63:0] rcv;
	logic [6:0] n;
	int fail_count;
	int checks_done;
	logic [31:0] seed;
	logic want;
	logic [31:0] rd;
	logic [31:0] exq[$];
	logic [31:0] mkq[$];
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	jtce_top DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tdi_pin(tdi_pin), .tap_pins(tap_pins));
	jtce_target u_tgt (.tck(tap_pins.tck), .tms(tap_pins.tms), .tdo(tap_pins.tdo), .clr(clr),
		.pat(pat), .tdi_pin(tdi_pin), .st(st), .rcv(rcv), .n(n));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic logic [31:0] endtap(input logic [1:0] e);
		return (e == 2'h2) ? 32'h6 : ((e == 2'h3) ? 32'hd : 32'h1);
	endfunction : endtap
	// One bus transfer; the request holds until ready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
		input logic [31:0] e, input logic [31:0] m);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		want <= c;
		if (c)
		begin
			exq.push_back(e & m);
			mkq.push_back(m);
		end
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		want <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
	endtask : wr
	task automatic rx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, 1'b1, e, m);
	endtask : rx
	task automatic load(input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wr(jtce_pkg::A_CNT, {24'h0, v[8*i +: 8]});
	endtask : load
	// Poll the command word until the opcode falls back to null.
	task automatic finish_cmd;
		int k;
		k = 0;
		rd = 32'h1;
		while (rd[3:0] !== 4'h0 && k < 2000)
		begin
			apb(1'b0, jtce_pkg::A_CMD, 32'h0, 1'b0, 32'h0, 32'h0);
			k++;
		end
		check({31'h0, k < 2000}, 32'h1);
	endtask : finish_cmd
	task automatic reset_look;
		rx(jtce_pkg::A_STAT, 32'h0, 32'h2f);
		for (int i = 0; i < 4; i++)
			rx(jtce_pkg::A_CNT, 32'h0, 32'hff);
	endtask : reset_look
	// A 16-bit scan of any kind; the chain model supplies and records bits.
	task automatic scan(input logic [3:0] op);
		logic [1:0] k;
		logic [3:0] s0;
		logic [31:0] tx;
		logic utx;
		logic urx;
		k = op[2:1];
		utx = (op == 4'h4) || (op == 4'h5) || (op[3] && !k[0]);
		urx = (op == 4'h3) || (op == 4'h4) || (op[3] && k != 2'h2);
		seed = xs(seed);
		tx = seed;
		seed = xs(seed);
		pat <= {seed, seed};
		s0 = st;
		clr <= 1'b1;
		load(32'h10);
		clr <= 1'b0;
		wr(jtce_pkg::A_CMD, {26'h0, seed[1:0], op});
		if (utx)
		begin
			wr(jtce_pkg::A_TXB, {24'h0, tx[7:0]});
			wr(jtce_pkg::A_TXB, {24'h0, tx[15:8]});
		end
		if (urx && op[3])
		begin
			rx(jtce_pkg::A_RXB, {24'h0, seed[7:0]}, 32'hff);
			rx(jtce_pkg::A_RXB, {24'h0, seed[15:8]}, 32'hff);
		end
		finish_cmd;
		if (!op[3])
		begin
			rx(jtce_pkg::A_STAT, {28'h0, s0}, 32'hf);
			check({28'h0, st}, {28'h0, s0});
		end
		else
		begin
			check({28'h0, st}, endtap(seed[1:0]));
			check({25'h0, n}, 32'h10);
			if (k == 2'h1)
				check({16'h0, rcv[15:0]}, 32'hffff);
			if (utx)
				check({16'h0, rcv[15:0]}, {16'h0, tx[15:0]});
			if (k == 2'h2)
				rx(jtce_pkg::A_RXB, 32'h0, 32'hff);
		end
	endtask : scan
	// Starve a 40-bit output scan after 32 bits, look at the stall, then feed it.
	task automatic stall(input logic [7:0] cfg, input logic [3:0] hold);
		int k;
		wr(jtce_pkg::A_SETUP2, {24'h0, cfg});
		seed = xs(seed);
		clr <= 1'b1;
		load(32'h28);
		clr <= 1'b0;
		wr(jtce_pkg::A_CMD, {26'h0, 2'h1, 4'hd});
		for (int i = 0; i < 4; i++)
			wr(jtce_pkg::A_TXB, {24'h0, seed[8*i +: 8]});
		k = 0;
		while (n !== 7'h20 && k < 3000)
		begin
			@(posedge clock);
			k++;
		end
		repeat (200) @(posedge clock);
		check({28'h0, st}, {28'h0, hold});
		check({25'h0, n}, 32'h20);
		wr(jtce_pkg::A_TXB, {24'h0, ~seed[7:0]});
		finish_cmd;
		check(rcv[31:0], seed);
		check({24'h0, rcv[39:32]}, {24'h0, ~seed[7:0]});
	endtask : stall
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	// Completed reads are compared against the oldest queued note.
	always @(posedge clock)
	begin
		if (psel && penable && pready && !pwrite && want)
			check(prdata & mkq.pop_front(), exq.pop_front());
	end
	initial
	begin
		repeat (90000) @(posedge clock);
		fail_count++;
		$display("Error at %0t: run did not finish", $time);
		test_done;
	end
	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		want = 1'b0;
		clr = 1'b0;
		pat = 64'h0;
		fail_count = 0;
		checks_done = 0;
		seed = 32'd9554;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		reset_look;
		rx(8'h1c, 32'h0, 32'hffffffff);
		seed = xs(seed);
		for (int i = 0; i < 3; i++)
			wr(jtce_pkg::A_CNT, {24'h0, seed[8*i +: 8]});
		rx(jtce_pkg::A_STAT, 32'h0, 32'h20);
		wr(jtce_pkg::A_CNT, {24'h0, seed[31:24]});
		rx(jtce_pkg::A_STAT, 32'h20, 32'h20);
		for (int i = 0; i < 4; i++)
			rx(jtce_pkg::A_CNT, {24'h0, seed[8*i +: 8]}, 32'hff);
		rx(jtce_pkg::A_STAT, 32'h20, 32'h20);
		wr(jtce_pkg::A_SETUP1, 32'h1);
		wr(jtce_pkg::A_CMD, {28'h0, jtce_pkg::OP_RUN});
		rx(jtce_pkg::A_CMD, 32'h0, 32'hf);
		repeat (40) @(posedge clock);
		check({28'h0, st}, 32'h0);
		wr(jtce_pkg::A_SETUP1, 32'h0);
		for (int e = 1; e < 4; e++)
		begin
			wr(jtce_pkg::A_CMD, {26'h0, e[1:0], jtce_pkg::OP_MOVE});
			finish_cmd;
			check({28'h0, st}, endtap(e[1:0]));
			rx(jtce_pkg::A_STAT, endtap(e[1:0]), 32'hf);
		end
		wr(jtce_pkg::A_CMD, {26'h0, 2'h1, jtce_pkg::OP_JUMP});
		finish_cmd;
		rx(jtce_pkg::A_STAT, 32'h1, 32'hf);
		check({28'h0, st}, 32'hd);
		wr(jtce_pkg::A_CMD, {26'h0, 2'h3, jtce_pkg::OP_JUMP});
		finish_cmd;
		load(32'h5);
		wr(jtce_pkg::A_CMD, {26'h0, 2'h2, jtce_pkg::OP_RUN});
		wr(jtce_pkg::A_CNT, 32'h7);
		finish_cmd;
		check({28'h0, st}, 32'h6);
		rx(jtce_pkg::A_STAT, 32'h20, 32'h20);
		for (int i = 0; i < 4; i++)
			rx(jtce_pkg::A_CNT, 32'h0, 32'hff);
		for (int op = 3; op < 16; op++)
		begin
			if (op != 6 && op != 7)
				scan(op[3:0]);
		end
		stall(8'h80, 4'h6);
		stall(8'h90, 4'h4);
		load(seed);
		wr(jtce_pkg::A_CMD, 32'h80);
		reset_look;
		rx(jtce_pkg::A_SETUP2, 32'h80, 32'hf0);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		reset_look;
		test_done;
	end
endmodule : testbench
bind jtce_top jtce_asserts u_chk (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tdi_pin(tdi_pin), .tap_pins(tap_pins));
`default_nettype wire
